// file: core/btcc_top.v
// Bus trace capture controller with APB registers
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "btcc_defines.vh"
module btcc_top #(
    parameter AW = 17,
    parameter DEPTH = 131072,
    parameter TW = 24
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Observed target bus
    input wire tgt_valid,
    input wire tgt_dma,
    input wire [31:0] tgt_addr,
    input wire [31:0] tgt_data,
    input wire tgt_rw,
    // Condition logic
    input wire trace_stop_hit,
    output wire cond_active,
    output reg cond_clear,
    // Outputs to emulator
    output reg target_break,
    output reg cfg_store_pulse,
    output reg [31:0] cfg_store_data,
    output wire irq
);
    localparam [31:0] T1_CYC = `BTCC_T1_PS / `BTCC_CLK_PS;
    localparam [31:0] T2_CYC = `BTCC_T2_PS / `BTCC_CLK_PS;
    localparam [31:0] T3_CYC = `BTCC_T3_PS / `BTCC_CLK_PS;
    localparam DW = 32 + 32 + 2 + TW;
    localparam CAP_RUN = 2'd0;
    localparam CAP_HOLD = 2'd1;
    localparam CAP_RESTART = 2'd2;

    reg [2:0] ctrl_r;
    reg [31:0] mode_r;
    reg [12:0] items_r;
    reg signed [31:0] pstart_r;
    reg signed [31:0] pend_r;
    reg [`BTCC_IRQ_W-1:0] irq_stat_r;
    reg [`BTCC_IRQ_W-1:0] irq_en_r;
    reg cfg_pending_r;
    reg [AW-1:0] rd_ptr_r;
    reg [1:0] cap_state_r;
    reg [1:0] cap_state_nxt;
    reg [31:0] tdiv_r;
    reg [TW-1:0] tstamp_r;
    wire [AW-1:0] wr_ptr;
    wire [AW:0] count;
    wire [DW-1:0] rd_data;
    wire ovf_pulse;
    reg restart_r;
    reg stop_par_r;

    wire wr_acc = psel & penable & pwrite;
    wire [1:0] time_code = mode_r[`BTCC_MODE_TIME_LO+1:`BTCC_MODE_TIME_LO];
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Stop hit holds parallel mode until next control write; set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stop_par_r <= 1'b0;
        else if (trace_stop_hit)
            stop_par_r <= 1'b1;
        else if (wr_acc && (paddr == `BTCC_OFF_CTRL))
            stop_par_r <= 1'b0;
    end

    // Return/stop parallel mode or a running command suspends capture
    wire suspend = ctrl_r[`BTCC_CTRL_PAR_RET] | ctrl_r[`BTCC_CTRL_CMD_BUSY]
        | stop_par_r;
    assign cond_active = (cap_state_r == CAP_RUN);

    // Capture sequencer
    always @* begin
        cap_state_nxt = cap_state_r;
        case (cap_state_r)
            CAP_RUN: if (suspend) cap_state_nxt = CAP_HOLD;
            CAP_HOLD: if (!suspend) cap_state_nxt = CAP_RESTART;
            CAP_RESTART: cap_state_nxt = suspend ? CAP_HOLD : CAP_RUN;
            default: cap_state_nxt = CAP_RUN;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_state_r <= CAP_RUN;
            cond_clear <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            cap_state_r <= cap_state_nxt;
            cond_clear <= (cap_state_r == CAP_HOLD) && !suspend;
            restart_r <= (cap_state_r == CAP_HOLD) && !suspend;
        end
    end

    // Time stamp prescaler selected by the time unit code
    reg [31:0] tdiv_max;
    always @* begin
        case (time_code)
            2'd1: tdiv_max = T1_CYC - 1;
            2'd2: tdiv_max = T2_CYC - 1;
            2'd3: tdiv_max = T3_CYC - 1;
            default: tdiv_max = 32'h0000_0000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdiv_r <= 32'h0000_0000;
            tstamp_r <= {TW{1'b0}};
        end else if (restart_r) begin
            tdiv_r <= 32'h0000_0000;
            tstamp_r <= {TW{1'b0}};
        end else if (tdiv_r >= tdiv_max) begin
            tdiv_r <= 32'h0000_0000;
            tstamp_r <= tstamp_r + 1'b1;
        end else begin
            tdiv_r <= tdiv_r + 1'b1;
        end
    end

    // Capture qualifier: DMA filter and run state
    wire cap_en = tgt_valid && (cap_state_r == CAP_RUN) && !suspend
        && (mode_r[`BTCC_MODE_DMA] || !tgt_dma);
    wire [DW-1:0] entry = {tstamp_r, tgt_dma, tgt_rw, tgt_data, tgt_addr};

    btcc_trace_buf #(
        .AW(AW),
        .DEPTH(DEPTH),
        .DW(DW)
    ) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .clear(restart_r),
        .wr_en(cap_en),
        .wr_data(entry),
        .rd_ptr(rd_ptr_r),
        .rd_data(rd_data),
        .count(count),
        .wr_ptr(wr_ptr),
        .ovf_pulse(ovf_pulse)
    );

    // Pointer clamp
    wire signed [31:0] wv = pwdata;
    wire signed [31:0] ps_clamped = (wv < `BTCC_PTR_MIN || wv > `BTCC_PTR_MAX)
        ? `BTCC_PTR_MIN : wv;
    wire signed [31:0] pe_clamped = (wv < `BTCC_PTR_MIN || wv > `BTCC_PTR_MAX)
        ? `BTCC_PTR_MAX : wv;

    // Display item write with time/clock exclusion
    wire items_bad = pwdata[`BTCC_ITEM_TIME] & pwdata[`BTCC_ITEM_CLK];

    // Register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 3'h0;
            mode_r <= `BTCC_MODE_RST;
            items_r <= `BTCC_ITEMS_RST;
            pstart_r <= `BTCC_PSTART_RST;
            pend_r <= `BTCC_PEND_RST;
            irq_en_r <= {`BTCC_IRQ_W{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
        end else if (wr_acc) begin
            case (paddr)
                `BTCC_OFF_CTRL: ctrl_r <= pwdata[2:0];
                `BTCC_OFF_MODE: mode_r <= {28'h0000000, pwdata[3:0]};
                `BTCC_OFF_ITEMS: if (!items_bad) items_r <= pwdata[12:0];
                `BTCC_OFF_PSTART: pstart_r <= ps_clamped;
                `BTCC_OFF_PEND: pend_r <= pe_clamped;
                `BTCC_OFF_IRQ_EN: irq_en_r <= pwdata[`BTCC_IRQ_W-1:0];
                `BTCC_OFF_RDPTR: rd_ptr_r <= pwdata[AW-1:0];
                default: ;
            endcase
        end
    end

    // Flash store with operator confirmation
    wire cfg_wr = wr_acc && (paddr == `BTCC_OFF_CFG);
    wire cfg_yes = cfg_wr && cfg_pending_r && pwdata[`BTCC_CFG_YES];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_pending_r <= 1'b0;
            cfg_store_pulse <= 1'b0;
            cfg_store_data <= 32'h0000_0000;
        end else begin
            cfg_store_pulse <= cfg_yes;
            if (cfg_wr && pwdata[`BTCC_CFG_REQ])
                cfg_pending_r <= 1'b1;
            else if (cfg_wr && (pwdata[`BTCC_CFG_YES] || pwdata[`BTCC_CFG_NO]))
                cfg_pending_r <= 1'b0;
            if (cfg_yes)
                cfg_store_data <= {15'h0000, items_r, mode_r[3:0]};
        end
    end

    // Interrupt events: set wins over clear
    wire [`BTCC_IRQ_W-1:0] ev = {wr_acc && paddr == `BTCC_OFF_ITEMS && items_bad,
        cfg_yes, restart_r, ovf_pulse};
    wire [`BTCC_IRQ_W-1:0] clr = (wr_acc && paddr == `BTCC_OFF_IRQ_CLR)
        ? pwdata[`BTCC_IRQ_W-1:0] : {`BTCC_IRQ_W{1'b0}};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_stat_r <= {`BTCC_IRQ_W{1'b0}};
        else
            irq_stat_r <= (irq_stat_r & ~clr) | ev;
    end
    assign irq = |(irq_stat_r & irq_en_r);

    // Overflow break request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            target_break <= 1'b0;
        else
            target_break <= ovf_pulse & mode_r[`BTCC_MODE_BREAK_ON_BUFFER_OVERFLOW];
    end

    // Register reads
    always @* begin
        case (paddr)
            `BTCC_OFF_CTRL: prdata = {29'h0, ctrl_r};
            `BTCC_OFF_MODE: prdata = mode_r;
            `BTCC_OFF_ITEMS: prdata = {19'h0, items_r};
            `BTCC_OFF_PSTART: prdata = pstart_r;
            `BTCC_OFF_PEND: prdata = pend_r;
            `BTCC_OFF_STATUS: prdata = {28'h0, stop_par_r, cfg_pending_r, cap_state_r};
            `BTCC_OFF_IRQ_STAT: prdata = {28'h0, irq_stat_r};
            `BTCC_OFF_IRQ_EN: prdata = {28'h0, irq_en_r};
            `BTCC_OFF_COUNT: prdata = {{(31-AW){1'b0}}, count};
            `BTCC_OFF_RDPTR: prdata = {{(32-AW){1'b0}}, wr_ptr};
            `BTCC_OFF_RDDATA: prdata = rd_data[31:0];
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule

// file: core/btcc_defines.vh
// Constants for the bus trace capture controller
`ifndef BTCC_DEFINES_VH
`define BTCC_DEFINES_VH
`define BTCC_OFF_CTRL 12'h000
`define BTCC_OFF_MODE 12'h004
`define BTCC_OFF_ITEMS 12'h008
`define BTCC_OFF_PSTART 12'h00C
`define BTCC_OFF_PEND 12'h010
`define BTCC_OFF_STATUS 12'h014
`define BTCC_OFF_IRQ_STAT 12'h018
`define BTCC_OFF_IRQ_CLR 12'h01C
`define BTCC_OFF_IRQ_EN 12'h020
`define BTCC_OFF_COUNT 12'h024
`define BTCC_OFF_CFG 12'h028
`define BTCC_OFF_RDPTR 12'h02C
`define BTCC_OFF_RDDATA 12'h030
// Control bits
`define BTCC_CTRL_PAR_RET 0
`define BTCC_CTRL_PAR_SPACE 1
`define BTCC_CTRL_CMD_BUSY 2
// Mode fields
`define BTCC_MODE_DMA 0
`define BTCC_MODE_BREAK_ON_BUFFER_OVERFLOW 1
`define BTCC_MODE_TIME_LO 2
`define BTCC_MODE_RST 32'h0000_0005
// Display items: 13 enables, time stamp bit 11, clock count bit 12
`define BTCC_ITEM_TIME 11
`define BTCC_ITEM_CLK 12
`define BTCC_ITEMS_RST 13'h07FF
// Pointer limits and defaults
`define BTCC_PTR_MAX 32'sd131070
`define BTCC_PTR_MIN (-32'sd131070)
`define BTCC_PSTART_RST 32'hFFFF_F001
`define BTCC_PEND_RST 32'h0000_0FFF
// Config store bits
`define BTCC_CFG_REQ 0
`define BTCC_CFG_YES 1
`define BTCC_CFG_NO 2
// Interrupt bits
`define BTCC_IRQ_OVF 0
`define BTCC_IRQ_RESTART 1
`define BTCC_IRQ_STORED 2
`define BTCC_IRQ_REJECT 3
`define BTCC_IRQ_W 4
// Time units in picoseconds and clock period
`define BTCC_CLK_PS 10000
`define BTCC_T1_PS 20000
`define BTCC_T2_PS 1600000
`define BTCC_T3_PS 52000000
`endif

// file: core/btcc_trace_buf.v
// Circular trace store with overflow indication
`timescale 1ns/1ps
module btcc_trace_buf #(
    parameter AW = 17,
    parameter DEPTH = 131072,
    parameter DW = 64
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write side
    input wire clear,
    input wire wr_en,
    input wire [DW-1:0] wr_data,
    // Read side
    input wire [AW-1:0] rd_ptr,
    output reg [DW-1:0] rd_data,
    // State
    output reg [AW:0] count,
    output reg [AW-1:0] wr_ptr,
    output reg ovf_pulse
);
    reg [DW-1:0] mem [0:DEPTH-1];
    wire full = (count == DEPTH);

    // Storage array, one entry per bus cycle
    always @(posedge pclk) begin
        if (wr_en)
            mem[wr_ptr] <= wr_data;
        rd_data <= mem[rd_ptr];
    end

    // Pointer, fill level and overwrite flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            ovf_pulse <= 1'b0;
        end else if (clear) begin
            wr_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            ovf_pulse <= 1'b0;
        end else begin
            ovf_pulse <= wr_en & full;
            if (wr_en) begin
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
                if (!full)
                    count <= count + 1'b1;
            end
        end
    end
endmodule

// file: testbench/btcc_sva.sv
// Port checker of the trace capture controller
`timescale 1ns/1ps
module btcc_sva (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // Capture and store controls
    input wire trace_stop_hit,
    input wire cond_active,
    input wire cond_clear,
    input wire cfg_store_pulse
);
    // Writes taken at this edge
    wire wr = psel && penable && pwrite && pready;
    wire ctl = wr && paddr == 12'h000;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_apb_okay: assert property (pready && !pslverr) else $error("bad answer");
    chk_halt_capture: assert property (
        ctl && (pwdata[0] || pwdata[2]) |-> ##2 !cond_active) else $error("no halt");
    chk_stop_halts: assert property (
        trace_stop_hit |-> ##2 !cond_active) else $error("no halt on stop hit");
    chk_space_keeps: assert property (
        ctl && pwdata[2:0] == 3'h2 && cond_active |=> cond_active) else $error("stopped");
    chk_fell_cause: assert property (
        $fell(cond_active) |-> $past(ctl || trace_stop_hit, 2)) else $error("halt without command");
    chk_rise_clear: assert property (
        $rose(cond_active) |-> $past(cond_clear)) else $error("resume without clear");
    chk_clear_resume: assert property (
        cond_clear |-> !cond_active ##1 cond_active) else $error("no resume");
    chk_clear_pulse: assert property (
        cond_clear |=> !cond_clear) else $error("clear too long");
    chk_store_cause: assert property (
        cfg_store_pulse |-> $past(wr && paddr == 12'h028 && pwdata[1])) else $error("store");
endmodule
bind btcc_top btcc_sva i_btcc_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .trace_stop_hit(trace_stop_hit), .cond_active(cond_active),
    .cond_clear(cond_clear),
    .cfg_store_pulse(cfg_store_pulse));

// file: testbench/btcc_tgt_model.sv
// Observed target bus: random cycles, counted
`timescale 1ns/1ps
module btcc_tgt_model (
    // Clock, reset, run request
    input wire pclk,
    input wire presetn,
    input wire go,
    // Bus cycle
    output reg tgt_valid,
    output reg tgt_dma,
    output reg [31:0] tgt_addr,
    output reg [31:0] tgt_data,
    output reg tgt_rw,
    // Cycles issued, all and DMA
    output reg [31:0] n_all,
    output reg [31:0] n_dma
);
    // Random gaps; lines change each cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tgt_valid, tgt_dma, tgt_rw, tgt_addr, tgt_data} <= 67'h0;
            n_all <= 32'h0;
            n_dma <= 32'h0;
        end else begin
            n_all <= n_all + tgt_valid;
            n_dma <= n_dma + (tgt_valid & tgt_dma);
            tgt_valid <= go && $urandom % 2;
            {tgt_dma, tgt_rw} <= $urandom % 4;
            tgt_addr <= $urandom;
            tgt_data <= $urandom;
        end
    end
endmodule

// file: testbench/btcc_top_test.sv
// Self-checking bench of the trace capture controller
`timescale 1ns/1ps
module btcc_top_test;
    localparam D = 16;
    reg pclk, presetn, psel, penable, pwrite, go, stop;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    wire [31:0] prdata, n_all, n_dma, tgt_addr, tgt_data, cfg_data;
    wire pready, pslverr, tgt_valid, tgt_dma, tgt_rw, cond_active, cond_clear;
    wire target_break, cfg_store_pulse, irq;
    integer n_mismatch, n_compared, i, v, b, d;
    integer n_brk = 0;
    integer n_cfg = 0;
    integer pv [0:3] = '{131070, -131071, 131071, -131070};
    // Design with a short store, and the bus model
    btcc_top #(.AW(4), .DEPTH(D)) i_btcc_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tgt_valid(tgt_valid),
        .tgt_dma(tgt_dma), .tgt_addr(tgt_addr), .tgt_data(tgt_data), .tgt_rw(tgt_rw),
        .trace_stop_hit(stop), .cond_active(cond_active), .cond_clear(cond_clear),
        .target_break(target_break), .cfg_store_pulse(cfg_store_pulse),
        .cfg_store_data(cfg_data), .irq(irq));
    btcc_tgt_model i_btcc_tgt_model (.pclk(pclk), .presetn(presetn), .go(go),
        .tgt_valid(tgt_valid), .tgt_dma(tgt_dma), .tgt_addr(tgt_addr),
        .tgt_data(tgt_data), .tgt_rw(tgt_rw), .n_all(n_all), .n_dma(n_dma));
    // Expected pointer after clamping
    function [31:0] clamp(input integer x, input reg e);
        if (x > 131070 || x < -131070) clamp = e ? 32'h0001FFFE : 32'hFFFE0002;
        else clamp = x;
    endfunction
    task end_of_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task cmp(input [31:0] g, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    // APB transfer, waits for pready
    task apb(input w, input [11:0] a, input [31:0] x);
        begin
            @(posedge pclk);
            {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, x};
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            {psel, penable} <= 2'h0;
        end
    endtask
    task chk(input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            cmp(rd, e);
        end
    endtask
    task run(input integer n);
        begin
            go <= 1'b1;
            repeat (n) @(posedge pclk);
            go <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Watchdog
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        end_of_test;
    end
    // Count one-cycle pulses
    always @(posedge pclk) begin
        if (target_break === 1'b1) n_brk <= n_brk + 1;
        if (cfg_store_pulse === 1'b1) n_cfg <= n_cfg + 1;
    end
    initial begin
        {presetn, psel, penable, pwrite, go, stop, paddr, pwdata} = 50'h0;
        n_mismatch = 0;
        n_compared = 0;
        i = $urandom(32'h7F72);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped place
        chk(12'h004, 32'h5);
        chk(12'h008, 32'h7FF);
        chk(12'h00C, 32'hFFFFF001);
        chk(12'h010, 32'h00000FFF);
        chk(12'h3FC, 32'h0);
        // Pointer limits, then random
        for (i = 0; i < 6; i = i + 1) begin
            v = i < 4 ? pv[i] : $urandom % 400000 - 200000;
            apb(1'b1, 12'h00C, v);
            chk(12'h00C, clamp(v, 1'b0));
            apb(1'b1, 12'h010, v);
            chk(12'h010, clamp(v, 1'b1));
        end
        // Item enables, refused pair, masked interrupt
        v = $urandom & 32'h17FF;
        apb(1'b1, 12'h008, v);
        apb(1'b1, 12'h008, 32'h1800);
        chk(12'h008, v);
        chk(12'h018, 32'h8);
        #1 cmp(irq, 32'h0);
        apb(1'b1, 12'h020, 32'hF);
        #1 cmp(irq, 32'h1);
        apb(1'b1, 12'h01C, 32'hF);
        #1 cmp(irq, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, 12'h004, i * 4 + 1);
            chk(12'h004, i * 4 + 1);
        end
        // Capture, suspend, restart
        run(8);
        d = n_all;
        chk(12'h024, d);
        apb(1'b1, 12'h000, 32'h1);
        run(8);
        chk(12'h024, d);
        apb(1'b1, 12'h000, 32'h0);
        chk(12'h024, 32'h0);
        chk(12'h018, 32'h2);
        apb(1'b1, 12'h000, 32'h2);
        b = n_all;
        run(8);
        chk(12'h024, n_all - b);
        apb(1'b1, 12'h000, 32'h6);
        @(posedge pclk);
        #1 cmp(cond_active, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        chk(12'h024, 32'h0);
        // DMA cycles left out
        apb(1'b1, 12'h004, 32'h4);
        b = n_all;
        d = n_dma;
        run(8);
        b = n_all - b - n_dma + d;
        chk(12'h024, b);
        // Stop condition hit: capture held until control write
        stop <= 1'b1;
        @(posedge pclk);
        stop <= 1'b0;
        run(8);
        chk(12'h024, b);
        #1 cmp(cond_active, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        chk(12'h024, 32'h0);
        // Overflow with and without break
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, 12'h004, 7 - 2 * i);
            apb(1'b1, 12'h000, 32'h4);
            apb(1'b1, 12'h000, 32'h0);
            apb(1'b1, 12'h01C, 32'hF);
            d = n_brk;
            b = n_all;
            run(60);
            chk(12'h024, n_all - b > D ? D : n_all - b);
            chk(12'h02C, (n_all - b) % D);
            chk(12'h018, n_all - b > D);
            cmp(n_brk - d, i == 0 && n_all - b > D ? n_all - b - D : 0);
        end
        // Store: no, then yes
        d = n_cfg;
        apb(1'b1, 12'h028, 32'h1);
        apb(1'b1, 12'h028, 32'h4);
        cmp(n_cfg - d, 32'h0);
        apb(1'b1, 12'h028, 32'h1);
        apb(1'b1, 12'h028, 32'h2);
        chk(12'h018, 32'h4 | (n_all - b > D));
        cmp(n_cfg - d, 32'h1);
        cmp(cfg_data, {15'h0000, v[12:0], 4'h5});
        end_of_test;
    end
endmodule
